// ---- wnl_ctrl.sv ----
// Wireless role, power gating, status indicator and DHCP pool logic with an APB register port.
// Assumes radio events and update status arrive on pclk; button and datalogger power level are pins.
//
// Function
// - Searching, joining or creating a network shows steady red.
// - Once the network is up, green pulses on network activity.
// - A failed connection strobes red twice repeatedly and retries after one minute.
// - Wireless turned off by button setting or datalogger instruction keeps the indicator dark unless an image copy or radio firmware transfer blinks it.
// - Image copy into flash blinks the indicator repeatedly, about ten seconds.
// - Radio firmware transfer blinks slowly, then faster toward completion.
// - Button disabled: presses ignored, network runs as configured.
// - Temporary enable: network normally off, a press powers it temporarily.
// - Temporary create in join role brings up an open network named from serial.
// - Create role with temporary create behaves exactly as temporary enable.
// - Temporary network times out after five minutes, refreshed by communication.
// - Another press while temporary network is active powers it down at once.
// - Create role uses WPA2 with a password, otherwise runs unencrypted.
// - Manual channel when set, otherwise least-interference channel.
// - A created network accepts at most eight stations.
// - Pool start is server plus 100, or minus 100 from octet 135 up.
// - Pool holds twenty entries, last address is start plus twenty.
// - Without a configured address the default server address and pool apply.
// - A configured address becomes the server address with the same pool rules.
// - Signal strength reads as dBm clamped to minus one hundred through zero.
// - Lost connectivity enters low power and retries about every minute.
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
module wnl_ctrl
   import wnl_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES,
   parameter int TEMP_MS  = TEMP_TIMEOUT_MS,
   parameter int RETRY_T  = RETRY_MS
) (
   // Clock and reset
   input  wire logic           pclk,
   input  wire logic           presetn,
   // APB slave
   input  wire logic           psel,
   input  wire logic           penable,
   input  wire logic           pwrite,
   input  wire logic [11:0]    paddr,
   input  wire logic [31:0]    pwdata,
   output logic      [31:0]    prdata,
   output logic                pready,
   output logic                pslverr,
   // Pins
   input  wire logic           mode_button,
   input  wire logic           datalogger_net_power_instruction,
   // Update engine
   input  wire logic           os_copy_active,
   input  wire logic           radio_fw_active,
   input  wire logic [7:0]     radio_fw_progress,
   // Radio module
   input  wire wnl_radio_evt_t radio_evt,
   input  wire logic [7:0]     radio_rssi,
   input  wire logic [3:0]     scan_best_channel,
   output wnl_radio_cmd_t      radio_cmd,
   output logic                radio_retry,
   output logic                station_accept,
   // Indicator
   output logic                led_red,
   output logic                led_green
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   localparam logic [17:0] TICK_END  = 18'(TICK_CYC - 1);
   localparam logic [18:0] TEMP_END  = 19'(TEMP_MS - 1);
   localparam logic [16:0] RETRY_END = 17'(RETRY_T - 1);
   localparam logic [4:0]  DB_END    = 5'(DEBOUNCE_MS - 1);

   wnl_ctrl_t      ctrl;
   logic [31:0]    ip_cfg;
   logic [31:0]    pool_first;
   logic [31:0]    pool_last;
   logic [31:0]    pool_next;
   logic [7:0]     rssi_reg;
   logic [17:0]    tick_cnt;
   logic           tick;
   logic           btn_s1, btn_s2, btn_stable, press;
   logic           dl_s1, dl_s2;
   logic [4:0]     db_cnt;
   logic           temp_active;
   logic [18:0]    temp_ms;
   logic           temp_mode;
   logic           net_enable;
   logic           powered;
   logic           serial_mode;
   wnl_net_state_t state;
   logic [16:0]    retry_ms;
   logic [3:0]     sta_count;
   logic [9:0]     phase_ms;
   logic [5:0]     act_ms;
   logic [9:0]     blink_ms;
   logic [9:0]     blink_half;
   logic           blink_lvl;
   logic           strobe;
   logic           next_red, next_green;
   logic [31:0]    server_ip;
   wnl_status_t    status;

   function automatic logic reg_known(input logic [11:0] a);
      return a == REG_CTRL || a == REG_STATUS || a == REG_IP ||
             a == REG_POOL_FIRST || a == REG_POOL_LAST || a == REG_RSSI;
   endfunction

   function automatic logic [31:0] pool_start(input logic [31:0] srv);
      logic [7:0] o;
      o = srv[7:0];
      return {srv[31:8], (o >= POOL_WRAP) ? 8'(o - POOL_OFFSET) : 8'(o + POOL_OFFSET)};
   endfunction

   // ****************************************************************
   // Time base and pin synchronisers
   // ****************************************************************
   // A one-millisecond enable keeps every long counter narrow.
   assign tick = (tick_cnt == TICK_END);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) tick_cnt <= 18'h00000;
      else if (tick) tick_cnt <= 18'h00000;
      else tick_cnt <= tick_cnt + 18'h00001;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         btn_s1 <= 1'b0;
         btn_s2 <= 1'b0;
         dl_s1  <= 1'b0;
         dl_s2  <= 1'b0;
      end else begin
         btn_s1 <= mode_button;
         btn_s2 <= btn_s1;
         dl_s1  <= datalogger_net_power_instruction;
         dl_s2  <= dl_s1;
      end
   end

   // Contact bounce shorter than the debounce window never reaches the stable level.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         db_cnt     <= 5'h00;
         btn_stable <= 1'b0;
         press      <= 1'b0;
      end else begin
         press <= 1'b0;
         if (btn_s2 == btn_stable) db_cnt <= 5'h00;
         else if (tick) begin
            if (db_cnt == DB_END) begin
               db_cnt     <= 5'h00;
               btn_stable <= btn_s2;
               press      <= btn_s2;
            end else db_cnt <= db_cnt + 5'h01;
         end
      end
   end

   // ****************************************************************
   // Power gating and temporary network
   // ****************************************************************
   assign temp_mode   = (ctrl.btn == BTN_TEMP_ENABLE) || (ctrl.btn == BTN_TEMP_CREATE);
   assign net_enable  = temp_mode ? temp_active : 1'b1;
   assign powered     = net_enable && dl_s2;
   assign serial_mode = (ctrl.btn == BTN_TEMP_CREATE) && !ctrl.role_create;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) temp_active <= 1'b0;
      else if (!temp_mode) temp_active <= 1'b0;
      else if (press) temp_active <= !temp_active;
      else if (temp_active && tick && temp_ms == TEMP_END && !radio_evt.activity) temp_active <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) temp_ms <= 19'h00000;
      else if (press || radio_evt.activity || !temp_active) temp_ms <= 19'h00000;
      else if (tick) temp_ms <= temp_ms + 19'h00001;
   end

   // ****************************************************************
   // Connection sequencer
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state       <= ST_OFF;
         radio_retry <= 1'b0;
      end else begin
         radio_retry <= 1'b0;
         if (!powered) state <= ST_OFF;
         else begin
            unique case (state)
               ST_OFF: begin
                  state       <= ST_SEARCH;
                  radio_retry <= 1'b1;
               end
               ST_SEARCH: begin
                  if (radio_evt.up) state <= ST_UP;
                  else if (radio_evt.fail) state <= ST_FAIL;
               end
               ST_UP: begin
                  if (radio_evt.lost) state <= ST_FAIL;
               end
               ST_FAIL: begin
                  if (tick && retry_ms == RETRY_END) begin
                     state       <= ST_SEARCH;
                     radio_retry <= 1'b1;
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) retry_ms <= 17'h00000;
      else if (state != ST_FAIL) retry_ms <= 17'h00000;
      else if (tick) retry_ms <= (retry_ms == RETRY_END) ? 17'h00000 : retry_ms + 17'h00001;
   end

   // Commands to the radio are registered so it never sees decode glitches.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) radio_cmd <= '0;
      else begin
         radio_cmd.power       <= powered;
         radio_cmd.low_power   <= (state == ST_FAIL);
         radio_cmd.role_create <= ctrl.role_create || serial_mode;
         radio_cmd.open_net    <= serial_mode || !ctrl.has_password;
         radio_cmd.serial_name <= serial_mode;
         radio_cmd.channel     <= (ctrl.channel != 4'h0) ? ctrl.channel : scan_best_channel;
      end
   end

   // Joins beyond the cap are refused; the radio must honour station_accept.
   assign station_accept = (sta_count < MAX_STATIONS);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) sta_count <= 4'h0;
      else if (state != ST_UP) sta_count <= 4'h0;
      else if (radio_evt.sta_join && station_accept && !(radio_evt.sta_leave && sta_count != 4'h0))
         sta_count <= sta_count + 4'h1;
      else if (radio_evt.sta_leave && sta_count != 4'h0 && !(radio_evt.sta_join && station_accept))
         sta_count <= sta_count - 4'h1;
   end

   // ****************************************************************
   // Indicator sequencer
   // ****************************************************************
   assign blink_half = os_copy_active ? COPY_HALF_MS :
                       10'(FW_SLOW_HALF_MS - {1'b0, radio_fw_progress, 1'b0});
   assign strobe     = (phase_ms < STROBE_ON_MS) ||
                       (phase_ms >= 10'(2 * STROBE_ON_MS) && phase_ms < 10'(3 * STROBE_ON_MS));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) phase_ms <= 10'h000;
      else if (tick) phase_ms <= (phase_ms == STROBE_PERIOD_MS - 10'h001) ? 10'h000 : phase_ms + 10'h001;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) act_ms <= 6'h00;
      else if (radio_evt.activity) act_ms <= ACT_PULSE_MS;
      else if (tick && act_ms != 6'h00) act_ms <= act_ms - 6'h01;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blink_ms  <= 10'h000;
         blink_lvl <= 1'b0;
      end else if (!(os_copy_active || radio_fw_active)) begin
         blink_ms  <= 10'h000;
         blink_lvl <= 1'b0;
      end else if (tick) begin
         if (blink_ms >= blink_half - 10'h001) begin
            blink_ms  <= 10'h000;
            blink_lvl <= !blink_lvl;
         end else blink_ms <= blink_ms + 10'h001;
      end
   end

   always_comb begin
      next_red   = 1'b0;
      next_green = 1'b0;
      if (os_copy_active) begin
         next_red   = blink_lvl;
         next_green = blink_lvl;
      end else if (radio_fw_active) next_green = blink_lvl;
      else begin
         unique case (state)
            ST_OFF:    next_red = 1'b0;
            ST_SEARCH: next_red = 1'b1;
            ST_UP:     next_green = (act_ms != 6'h00);
            ST_FAIL:   next_red = strobe;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         led_red   <= 1'b0;
         led_green <= 1'b0;
      end else begin
         led_red   <= next_red;
         led_green <= next_green;
      end
   end

   // ****************************************************************
   // DHCP pool and signal strength
   // ****************************************************************
   assign server_ip = (ip_cfg == 32'h00000000) ? DEFAULT_IP : ip_cfg;
   assign pool_next = pool_start(server_ip);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pool_first <= 32'h00000000;
         pool_last  <= 32'h00000000;
         rssi_reg   <= 8'h00;
      end else begin
         pool_first <= pool_next;
         pool_last  <= {pool_next[31:8], 8'(pool_next[7:0] + POOL_SIZE)};
         if ($signed(radio_rssi) < RSSI_MIN) rssi_reg <= RSSI_MIN;
         else if ($signed(radio_rssi) > RSSI_MAX) rssi_reg <= RSSI_MAX;
         else rssi_reg <= radio_rssi;
      end
   end

   // ****************************************************************
   // APB slave
   // ****************************************************************
   // Read data is captured in the setup cycle so the access phase needs no wait state.
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !reg_known(paddr);

   always_comb begin
      status             = '0;
      status.open_net    = radio_cmd.open_net;
      status.sta_count   = sta_count;
      status.channel     = radio_cmd.channel;
      status.temp_active = temp_active;
      status.powered     = powered;
      status.state       = state;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl   <= CTRL_RESET;
         ip_cfg <= IP_RESET;
      end else if (psel && penable && pwrite) begin
         if (paddr == REG_CTRL) ctrl <= {24'h000000, pwdata[7:0]};
         if (paddr == REG_IP) ip_cfg <= pwdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= 32'h00000000;
      else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            REG_CTRL:       prdata <= ctrl;
            REG_STATUS:     prdata <= status;
            REG_IP:         prdata <= ip_cfg;
            REG_POOL_FIRST: prdata <= pool_first;
            REG_POOL_LAST:  prdata <= pool_last;
            REG_RSSI:       prdata <= {24'h000000, rssi_reg};
            default:        prdata <= 32'h00000000;
         endcase
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_fail_expire;
      powered && state == ST_FAIL && tick && retry_ms == RETRY_END;
   endsequence
   sequence s_quiet_off;
      (!powered && !os_copy_active && !radio_fw_active) [*2];
   endsequence

   fail_retry_a: assert property (s_fail_expire |=> state == ST_SEARCH && radio_retry)
      else $error("failed connection did not retry after the wait");
   dark_off_a: assert property (s_quiet_off |=> !led_red && !led_green)
      else $error("indicator lit while wireless is off");
   search_red_a: assert property (powered && state == ST_SEARCH && !os_copy_active && !radio_fw_active
                                  |=> led_red && !led_green)
      else $error("search state not shown steady red");
   press_on_a: assert property (temp_mode && !temp_active && press |=> temp_active)
      else $error("press did not start temporary network");
   press_off_a: assert property (temp_mode && temp_active && press |=> !temp_active)
      else $error("press did not stop temporary network");
   temp_expire_a: assert property (temp_active && tick && temp_ms == TEMP_END && !press && !radio_evt.activity
                                   |=> !temp_active)
      else $error("temporary network outlived its timeout");
   disabled_on_a: assert property (ctrl.btn == BTN_DISABLED |-> net_enable)
      else $error("disabled button gated the network");
   pool_first_a: assert property ($past(presetn) |->
                                  pool_first[31:8] == $past(server_ip[31:8]) &&
                                  pool_first[7:0] == (($past(server_ip[7:0]) >= POOL_WRAP) ?
                                  8'($past(server_ip[7:0]) - POOL_OFFSET) :
                                  8'($past(server_ip[7:0]) + POOL_OFFSET)))
      else $error("pool start offset wrong");
   pool_last_a: assert property ($past(presetn) |->
                                 pool_last == {pool_first[31:8], 8'(pool_first[7:0] + POOL_SIZE)})
      else $error("pool end not start plus twenty");
   rssi_range_a: assert property ($signed(rssi_reg) >= RSSI_MIN && $signed(rssi_reg) <= RSSI_MAX)
      else $error("signal strength outside clamp range");
   sta_cap_a: assert property (sta_count <= MAX_STATIONS)
      else $error("station count above cap");

endmodule

// ---- wnl_pkg.sv ----
// Shared constants, register layout and carrier types for the wireless link control block.
// Assumes a single 200 MHz clock and an APB register port with 32-bit data.
package wnl_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS    = 5;
   localparam int TICK_PERIOD_NS   = 1000000;
   localparam int TICK_CYCLES      = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int MS_PER_S         = 1000;
   localparam int TEMP_TIMEOUT_MIN = 5;
   localparam int TEMP_TIMEOUT_MS  = TEMP_TIMEOUT_MIN * 60 * MS_PER_S;
   localparam int RETRY_S          = 60;
   localparam int RETRY_MS         = RETRY_S * MS_PER_S;
   localparam int DEBOUNCE_MS      = 20;
   localparam logic [9:0] STROBE_PERIOD_MS = 10'h3e8;
   localparam logic [9:0] STROBE_ON_MS     = 10'h064;
   localparam logic [9:0] COPY_HALF_MS     = 10'h064;
   localparam logic [9:0] FW_SLOW_HALF_MS  = 10'h208;
   localparam logic [5:0] ACT_PULSE_MS     = 6'h32;

   // ****************************************************************
   // Network figures
   // ****************************************************************
   localparam logic [3:0]  MAX_STATIONS = 4'h8;
   localparam logic [31:0] DEFAULT_IP   = 32'hc0a84301;
   localparam logic [7:0]  POOL_OFFSET  = 8'h64;
   localparam logic [7:0]  POOL_WRAP    = 8'h87;
   localparam logic [7:0]  POOL_SIZE    = 8'h14;
   localparam logic signed [7:0] RSSI_MIN = 8'sh9c;
   localparam logic signed [7:0] RSSI_MAX = 8'sh00;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [11:0] REG_CTRL       = 12'h000;
   localparam logic [11:0] REG_STATUS     = 12'h004;
   localparam logic [11:0] REG_IP         = 12'h008;
   localparam logic [11:0] REG_POOL_FIRST = 12'h00c;
   localparam logic [11:0] REG_POOL_LAST  = 12'h010;
   localparam logic [11:0] REG_RSSI       = 12'h014;
   localparam logic [31:0] CTRL_RESET     = 32'h00000001;
   localparam logic [31:0] IP_RESET       = 32'h00000000;

   typedef enum logic [1:0] {BTN_DISABLED, BTN_TEMP_ENABLE, BTN_TEMP_CREATE} wnl_btn_cfg_t;
   typedef enum logic [1:0] {ST_OFF, ST_SEARCH, ST_UP, ST_FAIL} wnl_net_state_t;

   typedef struct packed {
      logic [23:0]  rsvd;
      logic [3:0]   channel;
      logic         has_password;
      wnl_btn_cfg_t btn;
      logic         role_create;
   } wnl_ctrl_t;

   typedef struct packed {
      logic [18:0]    rsvd;
      logic           open_net;
      logic [3:0]     sta_count;
      logic [3:0]     channel;
      logic           temp_active;
      logic           powered;
      wnl_net_state_t state;
   } wnl_status_t;

   typedef struct packed {
      logic up;
      logic fail;
      logic lost;
      logic activity;
      logic sta_join;
      logic sta_leave;
   } wnl_radio_evt_t;

   typedef struct packed {
      logic       power;
      logic       low_power;
      logic       role_create;
      logic       open_net;
      logic       serial_name;
      logic [3:0] channel;
   } wnl_radio_cmd_t;

endpackage

// ---- wnl_radio_model.sv ----
// Behavioural radio module on the far side of the wireless link control block.
// Assumes event pulses one pclk cycle wide and commands sampled on the same clock.
`timescale 1ns/1ps
module wnl_radio_model
   import wnl_pkg::*;
(
   // Control block side
   input  wire logic           pclk,
   input  wire logic           presetn,
   input  wire wnl_radio_cmd_t radio_cmd,
   input  wire logic           radio_retry,
   output wnl_radio_evt_t      radio_evt,
   // Bench controls
   input  wire logic           fail_mode,
   input  wire logic [7:0]     delay,
   input  wire logic           act_req,
   input  wire logic           sta_req,
   input  wire logic           lost_req
);
   logic       pwr_q;
   logic [8:0] cnt;
   // Attempts answer after a settable delay, so slow and prompt radios are both seen.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_q     <= 1'b0;
         cnt       <= 9'h000;
         radio_evt <= '0;
      end else begin
         pwr_q     <= radio_cmd.power;
         radio_evt <= '{up: cnt == 9'h001 && !fail_mode, fail: cnt == 9'h001 && fail_mode,
                        activity: act_req, sta_join: sta_req, lost: lost_req, default: 1'b0};
         cnt       <= ((radio_cmd.power && !pwr_q) || radio_retry) ? {1'b0, delay} : cnt - (cnt != 9'h000);
      end
   end
endmodule

// ---- wnl_ctrl_tb.sv ----
// Self-checking bench for the wireless link control block.
// Assumes the package and radio model come first; parameters shrink the long timers.
`timescale 1ns/1ps
module wnl_ctrl_tb;
   import wnl_pkg::*;
   logic           pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, btn = 0, cp = 0, fw = 0, dl = 1;
   logic           fail_mode = 0, act_req = 0, sta_req = 0, lost_req = 0, pready, pslverr, radio_retry, station_accept;
   logic           led_red, led_green, err;
   logic [11:0]    paddr = '0;
   logic [31:0]    pwdata = '0, prdata, rv, ip;
   logic [7:0]     prog = '0, rssi = '0, delay = 8'h96, v;
   logic [3:0]     scan = 4'h3;
   wnl_radio_evt_t radio_evt;
   wnl_radio_cmd_t radio_cmd;
   int             error_cnt = 0, compares = 0, cyc = 0, n = 0, seed = 32'he12571a2;
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         test_done();
      end
   end
   wnl_ctrl #(.TICK_CYC(4), .TEMP_MS(50), .RETRY_T(20)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .mode_button(btn), .datalogger_net_power_instruction(dl),
      .os_copy_active(cp), .radio_fw_active(fw), .radio_fw_progress(prog), .radio_evt, .radio_rssi(rssi),
      .scan_best_channel(scan), .radio_cmd, .radio_retry, .station_accept, .led_red, .led_green);
   wnl_radio_model rad (.pclk, .presetn, .radio_cmd, .radio_retry, .radio_evt, .fail_mode, .delay, .act_req,
      .sta_req, .lost_req);
   task automatic test_done();
      if (error_cnt == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rv = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] m, e);
      apb(1'b0, a, '0);
      chk(rv & m, e);
   endtask
   task automatic kick(input logic a, s);
      {act_req, sta_req} <= {a, s};
      @(posedge pclk);
      {act_req, sta_req} <= 2'b00;
      @(posedge pclk);
   endtask
   // Waits on one of a few conditions; the bound makes a stuck design show up as a mismatch.
   task automatic wt(input int k, lim);
      for (n = 0; n < lim; n++) begin
         if ((k == 0 ? !led_red : k == 1 ? led_green : k == 2 ? radio_cmd.low_power :
              k == 3 ? radio_retry : led_red & led_green) === 1'b1) break;
         @(posedge pclk);
      end
      chk(n < lim, 1'b1);
   endtask
   task automatic press();
      btn <= 1'b1;
      repeat (120) @(posedge pclk);
      btn <= 1'b0;
      repeat (120) @(posedge pclk);
   endtask
   function automatic logic [31:0] pool(logic [31:0] a, logic [7:0] add);
      a = (a == '0) ? DEFAULT_IP : a;
      a[7:0] = ((a[7:0] >= POOL_WRAP) ? a[7:0] - POOL_OFFSET : a[7:0] + POOL_OFFSET) + add;
      return a;
   endfunction
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd(REG_CTRL, '1, CTRL_RESET);
      rd(REG_IP, '1, IP_RESET);
      rd(12'h018, '1, '0);
      chk(err, 1'b1);
      rd(REG_STATUS, 32'h3, 32'h1);
      chk(led_red, 1'b1);
      wt(0, 600);
      rd(REG_STATUS, 32'h3, 32'h2);
      kick(1'b1, 1'b0);
      wt(1, 20);
      repeat (9) kick(1'b0, 1'b1);
      rd(REG_STATUS, 32'hf00, 32'h800);
      chk(station_accept, 1'b0);
      for (int i = 0; i < 8; i++) begin
         ip = (i == 2) ? '0 : $random(seed);
         if (i < 2) ip[7:0] = 8'h86 + 8'(i);
         v = (i < 2) ? 8'h9b + 8'(i * 102) : 8'($random(seed));
         rssi <= v;
         apb(1'b1, REG_IP, ip);
         rd(REG_POOL_FIRST, '1, pool(ip, 8'h00));
         rd(REG_POOL_LAST, '1, pool(ip, POOL_SIZE));
         rd(REG_RSSI, 32'hff, ($signed(v) > RSSI_MAX) ? 8'h00 : ($signed(v) < RSSI_MIN) ? 8'h9c : v);
      end
      scan <= 4'($random(seed));
      apb(1'b1, REG_CTRL, 32'h59);
      rd(REG_CTRL, '1, 32'h59);
      chk({radio_cmd.open_net, radio_cmd.channel}, 5'h05);
      apb(1'b1, REG_CTRL, 32'h1);
      rd(REG_CTRL, '1, 32'h1);
      chk({radio_cmd.open_net, radio_cmd.channel}, {1'b1, scan});
      {fail_mode, delay, dl} <= {1'b1, 8'h10, 1'b0};
      repeat (4) @(posedge pclk);
      rd(REG_STATUS, 32'h7, 32'h0);
      chk(led_red | led_green, 1'b0);
      dl <= 1'b1;
      wt(2, 600);
      rd(REG_STATUS, 32'h3, 32'h3);
      wt(3, 300);
      fail_mode <= 1'b0;
      repeat (20) @(posedge pclk);
      lost_req <= 1'b1;
      @(posedge pclk);
      lost_req <= 1'b0;
      wt(2, 20);
      press();
      rd(REG_STATUS, 32'hc, 32'h4);
      apb(1'b1, REG_CTRL, 32'h3);
      rd(REG_STATUS, 32'hc, 32'h0);
      press();
      rd(REG_STATUS, 32'hc, 32'hc);
      repeat (5) begin
         kick(1'b1, 1'b0);
         repeat (60) @(posedge pclk);
      end
      rd(REG_STATUS, 32'hc, 32'hc);
      press();
      rd(REG_STATUS, 32'hc, 32'h0);
      press();
      repeat (300) @(posedge pclk);
      rd(REG_STATUS, 32'hc, 32'h0);
      apb(1'b1, REG_CTRL, 32'h4);
      press();
      chk(radio_cmd[8:4], 5'h17);
      kick(1'b1, 1'b0);
      press();
      apb(1'b1, REG_CTRL, 32'h5);
      rd(REG_STATUS, 32'hc, 32'h0);
      press();
      rd(REG_STATUS, 32'hc, 32'hc);
      cp <= 1'b1;
      wt(4, 900);
      {cp, fw, prog} <= {2'b01, 8'hff};
      wt(0, 900);
      wt(1, 100);
      test_done();
   end
endmodule
